// file: src/ppu_pkg.sv
/*
 * Shared constants, types and register map for the payload pattern unit.
 * Assumes a single clock domain and a plain strobe register port.
 */
package ppu_pkg;
    localparam int unsigned SLOTS     = 12;
    localparam int unsigned LFSR_W    = 23;
    localparam int unsigned TAP_A     = 23;
    localparam int unsigned TAP_B     = 18;
    localparam int unsigned LOCK_CNT  = 4;
    localparam int unsigned ADDR_W    = 4;
    localparam int unsigned CNT_W     = 16;

    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_PATH   = 4'h1;
    localparam logic [3:0] REG_B1VAL  = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_IND    = 4'h4;
    localparam logic [3:0] REG_DATA   = 4'h5;
    localparam logic [3:0] REG_INTST  = 4'h6;
    localparam logic [3:0] REG_INTMSK = 4'h7;

    localparam int unsigned CTRL_GEN_EN  = 0;
    localparam int unsigned CTRL_MON_EN  = 1;
    localparam int unsigned CTRL_INCR    = 2;
    localparam int unsigned CTRL_B1_EN   = 3;
    localparam int unsigned CTRL_REALIGN = 4;
    localparam int unsigned IND_SEL_BIT  = 4;
    localparam int unsigned IND_BUSY_BIT = 15;

    localparam int unsigned EV_SYNC   = 0;
    localparam int unsigned EV_LOSS   = 1;
    localparam int unsigned EV_ERR    = 2;
    localparam int unsigned EV_B1     = 3;
    localparam int unsigned EV_W      = 4;

    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;

    typedef enum logic [2:0] {
        PPU_HUNT  = 3'b001,
        PPU_CHECK = 3'b010,
        PPU_SYNC  = 3'b100
    } ppu_mon_state_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] slot;
        logic       b1;
        logic       e1;
        logic [7:0] data;
    } ppu_byte_t;

    typedef struct packed {
        logic [22:0]    lfsr;
        logic [1:0]     fill;
        logic [2:0]     run;
        ppu_mon_state_t state;
        logic [15:0]    errors;
    } ppu_chan_t;
endpackage : ppu_pkg

// file: src/ppu_prbs_step.sv
/*
 * Byte step of the pattern shift register: eight shifts at once.
 * Assumes a 23-stage register with feedback from stages 23 and 18.
 */
module ppu_prbs_step (
    // State in
    input  wire logic [22:0] state_in,
    // State and byte out
    output logic [22:0] state_out,
    output logic [7:0]  byte_out
);
    logic [30:0] ext;

    // Stage k of the extended vector is the feedback bit produced k-22 shifts later.
    always_comb begin
        ext = 31'h0000_0000;
        ext[22:0] = state_in;
        for (int k = 23; k < 31; k++) begin
            ext[k] = ext[k - ppu_pkg::TAP_A] ^ ext[k - ppu_pkg::TAP_B];
        end
    end

    assign state_out = ext[30:8];
    assign byte_out  = {ext[23], ext[24], ext[25], ext[26], ext[27], ext[28], ext[29], ext[30]};
endmodule : ppu_prbs_step

// file: src/ppu_slot_mem.sv
/*
 * Per-slot state store for the monitor, one word per time slot.
 * Read data come out of a register one cycle after the address.
 */
module ppu_slot_mem #(
    parameter int unsigned WIDTH = 8
) (
    // Clocking
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             ce,
    // Access
    input  wire logic [3:0]       rd_addr,
    output logic [WIDTH-1:0]      rd_data,
    input  wire logic             wr_en,
    input  wire logic [3:0]       wr_addr,
    input  wire logic [WIDTH-1:0] wr_data
);
    logic [WIDTH-1:0] mem [ppu_pkg::SLOTS];

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_data <= '0;
            for (int i = 0; i < ppu_pkg::SLOTS; i++) mem[i] <= '0;
        end else if (ce) begin
            if (wr_en) mem[wr_addr] <= wr_data;
            rd_data <= mem[rd_addr];
        end
    end
endmodule : ppu_slot_mem

// file: src/ppu_top.sv
/*
 * Payload pattern unit: generator and monitor for the STS-12 payload, twelve
 * interleaved STS-1 slots. Assumes slot numbers and B1/E1 markers arrive with
 * each byte, synchronous to clock.
 */
// Summary of operation
// - Generate and check an X^23+X^18+1 pseudo-random or an incrementing byte pattern in the payload.
// - Optionally compare a programmed value on every B1 byte and its complement on every E1 byte.
// - Handle one STS-12 payload as twelve time slots, grouping set individually for each group of three slots.
// - Allow one STS-12c, twelve STS-1, four STS-3c, or 3+3, 6+2, 9+1 mixes of STS-1 and STS-3c.
// - The register state is the last 23 of 24 bits received; the next byte is the next eight feedback bits.
// - Four received bytes of one payload recover the state, later bytes are predicted from it.
// - From recovery, four consecutive matching bytes are needed before declaring synchronised.
// - When synchronised, four consecutive mismatches drop sync and restart recovery automatically.
// - Setting the force realign bit drops sync and starts a fresh recovery on the one path in the monitor pipeline at that cycle.
// - Each mismatch while synchronised counts in a 16-bit counter that saturates at FFFFh.
// - An indirect read copies the count into the data register and clears the counter at once.
// - Errors only count while synchronised and are dropped otherwise.
// - Software waits for busy low, writes the path with the read select at 1, polls busy, then reads data.
module ppu_top (
    // Clocking
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic               ce,
    // Register port
    input  wire logic [3:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [15:0]             reg_rdata,
    // Receive stream
    input  wire ppu_pkg::ppu_byte_t rx_in,
    // Transmit stream
    input  wire ppu_pkg::ppu_byte_t tx_slot,
    output ppu_pkg::ppu_byte_t      tx_out,
    // Status
    output logic                    irq
);
    logic [15:0] ctrl;
    logic [3:0]  path_cfg;
    logic [7:0]  b1_value;
    logic [15:0] ind_data;
    logic [3:0]  ind_chan;
    logic        ind_busy;
    logic [ppu_pkg::EV_W-1:0] int_stat;
    logic [ppu_pkg::EV_W-1:0] int_mask;

    // Path grouping: bit g set makes slots 3g..3g+2 one STS-3c; ctrl[8] set makes STS-12c whatever the group bits.
    logic        cfg_12c;
    assign cfg_12c = ctrl[8];

    function automatic logic [3:0] path_of(input logic [3:0] slot, input logic [3:0] grp, input logic c12);
        logic [3:0] g;
        g = 4'(slot / 4'd3);
        if (c12) path_of = 4'h0;
        else if (grp[g[1:0]]) path_of = 4'(g * 4'd3);
        else path_of = slot;
    endfunction

    // Write decode.
    logic wr_ctrl, wr_path, wr_b1, wr_ind, wr_ist, wr_msk;
    assign wr_ctrl = reg_wr && reg_addr == ppu_pkg::REG_CTRL;
    assign wr_path = reg_wr && reg_addr == ppu_pkg::REG_PATH;
    assign wr_b1   = reg_wr && reg_addr == ppu_pkg::REG_B1VAL;
    assign wr_ind  = reg_wr && reg_addr == ppu_pkg::REG_IND && !ind_busy
                     && reg_wdata[ppu_pkg::IND_SEL_BIT];
    assign wr_ist  = reg_wr && reg_addr == ppu_pkg::REG_INTST;
    assign wr_msk  = reg_wr && reg_addr == ppu_pkg::REG_INTMSK;

    logic realign;
    assign realign = wr_ctrl && reg_wdata[ppu_pkg::CTRL_REALIGN];

    // Generator: per-path state, advanced only on that path's slots.
    logic [22:0] gen_state [ppu_pkg::SLOTS];
    logic [3:0]  tx_path;
    logic [22:0] gen_next;
    logic [7:0]  gen_byte;
    assign tx_path = path_of(tx_slot.slot, path_cfg, cfg_12c);

    ppu_prbs_step u_gen_step (
        .state_in  (gen_state[tx_path]),
        .state_out (gen_next),
        .byte_out  (gen_byte)
    );

    logic [7:0] gen_out;
    assign gen_out = ctrl[ppu_pkg::CTRL_INCR] ? 8'(gen_state[tx_path][7:0] + 8'h01) : gen_byte;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_out <= '0;
            for (int i = 0; i < ppu_pkg::SLOTS; i++) gen_state[i] <= 23'h7F_FFFF;
        end else if (ce) begin
            tx_out <= tx_slot;
            if (tx_slot.valid && ctrl[ppu_pkg::CTRL_GEN_EN] && !tx_slot.b1 && !tx_slot.e1) begin
                tx_out.data <= gen_out;
                gen_state[tx_path] <= ctrl[ppu_pkg::CTRL_INCR] ? {15'h0000, gen_out} : gen_next;
            end else if (tx_slot.valid && ctrl[ppu_pkg::CTRL_B1_EN] && tx_slot.b1) begin
                tx_out.data <= b1_value;
            end else if (tx_slot.valid && ctrl[ppu_pkg::CTRL_B1_EN] && tx_slot.e1) begin
                tx_out.data <= ~b1_value;
            end
        end
    end

    // Monitor: stage 1 reads slot state from memory, stage 2 evaluates and writes back.
    ppu_pkg::ppu_byte_t rx_q;
    logic [3:0]  rx_path, q_path;
    ppu_pkg::ppu_chan_t ch_rd, ch_wr;
    logic        ch_we;
    assign rx_path = path_of(rx_in.slot, path_cfg, cfg_12c);

    // Forwarding covers back-to-back bytes of the same path, e.g. in STS-12c.
    ppu_pkg::ppu_chan_t ch_cur;
    logic [3:0]  last_path;
    logic        last_we;
    ppu_pkg::ppu_chan_t last_wr;

    ppu_slot_mem #(.WIDTH($bits(ppu_pkg::ppu_chan_t))) u_mem (
        .clock   (clock),
        .nrst    (nrst),
        .ce      (ce),
        .rd_addr (rx_path),
        .rd_data (ch_rd),
        .wr_en   (ch_we),
        .wr_addr (q_path),
        .wr_data (ch_wr)
    );

    assign ch_cur = (last_we && last_path == q_path) ? last_wr : ch_rd;

    logic [22:0] mon_next;
    logic [7:0]  mon_byte;
    ppu_prbs_step u_mon_step (
        .state_in  (ch_cur.lfsr),
        .state_out (mon_next),
        .byte_out  (mon_byte)
    );

    logic [7:0] expect_byte;
    logic       match, pat_byte, b1_err;
    logic [22:0] shifted_in;
    assign expect_byte = ctrl[ppu_pkg::CTRL_INCR] ? 8'(ch_cur.lfsr[7:0] + 8'h01) : mon_byte;
    assign match       = expect_byte == rx_q.data;
    assign pat_byte    = rx_q.valid && !rx_q.b1 && !rx_q.e1 && ctrl[ppu_pkg::CTRL_MON_EN];
    assign b1_err      = rx_q.valid && ctrl[ppu_pkg::CTRL_B1_EN]
                         && ((rx_q.b1 && rx_q.data != b1_value) || (rx_q.e1 && rx_q.data != ~b1_value));
    // Newest bits enter at the top, as in the step module, so the eight oldest bits fall off the bottom.
    assign shifted_in  = {rx_q.data[0], rx_q.data[1], rx_q.data[2], rx_q.data[3],
                          rx_q.data[4], rx_q.data[5], rx_q.data[6], rx_q.data[7], ch_cur.lfsr[22:8]};

    logic ind_hit, ev_sync, ev_loss, ev_err;
    assign ind_hit = ind_busy && ind_chan == q_path;
    assign ch_we   = pat_byte || realign || ind_hit;

    always_comb begin
        ch_wr   = ch_cur;
        ev_sync = 1'b0;
        ev_loss = 1'b0;
        ev_err  = 1'b0;
        if (pat_byte) begin
            unique case (ch_cur.state)
                ppu_pkg::PPU_HUNT: begin
                    ch_wr.lfsr = ctrl[ppu_pkg::CTRL_INCR] ? {15'h0000, rx_q.data} : shifted_in;
                    ch_wr.fill = 2'(ch_cur.fill + 2'd1);
                    // Fourth byte completes recovery.
                    if (ch_cur.fill == 2'd3) begin
                        ch_wr.state = ppu_pkg::PPU_CHECK;
                        ch_wr.run   = 3'd0;
                    end
                end
                ppu_pkg::PPU_CHECK: begin
                    ch_wr.lfsr = ctrl[ppu_pkg::CTRL_INCR] ? {15'h0000, rx_q.data} : shifted_in;
                    if (!match) begin
                        ch_wr.run = 3'd0;
                    end else if (ch_cur.run == 3'(ppu_pkg::LOCK_CNT - 1)) begin
                        ch_wr.state = ppu_pkg::PPU_SYNC;
                        ch_wr.run   = 3'd0;
                        ev_sync     = 1'b1;
                    end else begin
                        ch_wr.run = 3'(ch_cur.run + 3'd1);
                    end
                end
                ppu_pkg::PPU_SYNC: begin
                    ch_wr.lfsr = ctrl[ppu_pkg::CTRL_INCR] ? {15'h0000, expect_byte} : mon_next;
                    if (match) begin
                        ch_wr.run = 3'd0;
                    end else begin
                        ev_err = 1'b1;
                        if (ch_cur.errors != ppu_pkg::CNT_MAX) ch_wr.errors = 16'(ch_cur.errors + 16'h0001);
                        if (ch_cur.run == 3'(ppu_pkg::LOCK_CNT - 1)) begin
                            ch_wr.state = ppu_pkg::PPU_HUNT;
                            ch_wr.fill  = 2'd0;
                            ch_wr.run   = 3'd0;
                            ev_loss     = 1'b1;
                        end else begin
                            ch_wr.run = 3'(ch_cur.run + 3'd1);
                        end
                    end
                end
                default: begin
                    ch_wr.state = ppu_pkg::PPU_HUNT;
                    ch_wr.fill  = 2'd0;
                end
            endcase
        end
        if (realign) begin
            ch_wr.state = ppu_pkg::PPU_HUNT;
            ch_wr.fill  = 2'd0;
            ch_wr.run   = 3'd0;
        end
        if (ind_hit) ch_wr.errors = ch_wr.errors == ch_cur.errors ? ppu_pkg::CNT_ZERO : 16'h0001;
    end

    // Realign only touches the slot in the pipeline; the other slots keep their state.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_q      <= '0;
            q_path    <= 4'h0;
            last_path <= 4'h0;
            last_we   <= 1'b0;
            last_wr   <= '0;
        end else if (ce) begin
            rx_q      <= rx_in;
            q_path    <= rx_path;
            last_path <= q_path;
            last_we   <= ch_we;
            last_wr   <= ch_wr;
        end
    end

    // Registers, indirect access and interrupts.
    logic [ppu_pkg::EV_W-1:0] ev_vec;
    assign ev_vec = {b1_err, ev_err, ev_loss, ev_sync};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl     <= 16'h0000;
            path_cfg <= 4'h0;
            b1_value <= 8'h00;
            ind_data <= 16'h0000;
            ind_chan <= 4'h0;
            ind_busy <= 1'b0;
            int_stat <= '0;
            int_mask <= '0;
        end else if (ce) begin
            if (wr_ctrl) ctrl <= reg_wdata & ~(16'h0001 << ppu_pkg::CTRL_REALIGN);
            if (wr_path) path_cfg <= reg_wdata[3:0];
            if (wr_b1)   b1_value <= reg_wdata[7:0];
            if (wr_msk)  int_mask <= reg_wdata[ppu_pkg::EV_W-1:0];
            // Set wins over the write-one clear.
            int_stat <= (int_stat & ~(wr_ist ? reg_wdata[ppu_pkg::EV_W-1:0] : '0)) | ev_vec;
            if (wr_ind) begin
                ind_chan <= reg_wdata[3:0];
                ind_busy <= 1'b1;
            end else if (ind_hit) begin
                // An error in the same cycle belongs to the fresh count, not to the copy.
                ind_data <= ch_cur.errors;
                ind_busy <= 1'b0;
            end
        end
    end

    assign irq = |(int_stat & int_mask);

    logic [15:0] rd_mux;
    assign rd_mux = reg_addr == ppu_pkg::REG_CTRL   ? ctrl :
                    reg_addr == ppu_pkg::REG_PATH   ? {12'h000, path_cfg} :
                    reg_addr == ppu_pkg::REG_B1VAL  ? {8'h00, b1_value} :
                    reg_addr == ppu_pkg::REG_STATUS ? {13'h0000, ch_rd.state} :
                    reg_addr == ppu_pkg::REG_IND    ? {ind_busy, 11'h000, ind_chan} :
                    reg_addr == ppu_pkg::REG_DATA   ? ind_data :
                    reg_addr == ppu_pkg::REG_INTST  ? {12'h000, int_stat} :
                    reg_addr == ppu_pkg::REG_INTMSK ? {12'h000, int_mask} : 16'h0000;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) reg_rdata <= 16'h0000;
        else if (ce) reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
endmodule : ppu_top

// file: tb/ppu_tb_pkg.sv
/* Reference step of the test pattern for the bench side.
   Assumes data[7] of each byte is the oldest bit on the line. */
package ppu_tb_pkg;
    // Returns the next state above the byte of eight new feedback bits.
    function automatic logic [30:0] prbs8(input logic [22:0] s);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < 8; i++) begin
            b = {b[6:0], s[22] ^ s[17]};
            s = {s[21:0], s[22] ^ s[17]};
        end
        return {s, b};
    endfunction : prbs8
endpackage : ppu_tb_pkg

// file: tb/ppu_src.sv
/* Far-end pattern source on the receive stream, twelve STS-1 paths.
   Assumes one clock and the byte format of the design package. */
module ppu_src (
    // Clocking
    input  wire logic          clock,
    input  wire logic          nrst,
    // Control
    input  wire logic          incr,
    input  wire logic          inj_ld,
    input  wire logic [3:0]    inj_n,
    // Stream
    output ppu_pkg::ppu_byte_t rx_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [22:0] st [12];
    logic [7:0]  cnt [12];
    logic [3:0]  slot;
    logic [3:0]  pend;
    logic [30:0] nx;
    logic        bad;
    assign nx = ppu_tb_pkg::prbs8(st[slot]);
    assign bad = slot == 4'h0 && pend != 4'h0;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            slot  <= 4'h0;
            pend  <= 4'h0;
            rx_in <= '0;
            for (int i = 0; i < 12; i++) begin
                st[i]  <= 23'h7F_FFFF;
                cnt[i] <= 8'h00;
            end
        end else begin
            slot       <= (slot == 4'hB) ? 4'h0 : slot + 4'h1;
            st[slot]   <= nx[30:8];
            cnt[slot]  <= cnt[slot] + 8'h01;
            pend       <= inj_ld ? inj_n : pend - {3'h0, bad};
            rx_in.valid <= 1'b1;
            rx_in.slot <= slot;
            // Corruption hits path 0 only, so its bytes stay consecutive in that path.
            rx_in.data <= (incr ? cnt[slot] + 8'h01 : nx[7:0]) ^ {7'h00, bad};
        end
    end
endmodule : ppu_src

// file: tb/ppu_props.sv
/* Port checks of the pattern unit, bound into ppu_top.
   Assumes clock enable held high; shadows registers from the write strobes. */
module ppu_props (
    // Clocking
    input wire logic               clock,
    input wire logic               nrst,
    input wire logic               ce,
    // Register port
    input wire logic [3:0]         reg_addr,
    input wire logic [15:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [15:0]        reg_rdata,
    // Streams and status
    input wire ppu_pkg::ppu_byte_t rx_in,
    input wire ppu_pkg::ppu_byte_t tx_slot,
    input wire ppu_pkg::ppu_byte_t tx_out,
    input wire logic               irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    logic [7:0]  ctrl;
    logic [7:0]  b1v;
    logic [23:0] hist;
    logic [1:0]  hcnt;
    logic [30:0] pnx;
    wire ctrl_wr = reg_wr && reg_addr == ppu_pkg::REG_CTRL;
    wire gen_q = tx_out.valid && tx_out.slot == 4'h0 && !tx_out.b1 && !tx_out.e1 && ctrl[0] && !ctrl[2];
    assign pnx = ppu_tb_pkg::prbs8(hist[22:0]);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl <= 8'h00;
            b1v  <= 8'h00;
            hist <= 24'h00_0000;
            hcnt <= 2'd0;
        end else begin
            if (ctrl_wr) ctrl <= reg_wdata[7:0];
            if (reg_wr && reg_addr == ppu_pkg::REG_B1VAL) b1v <= reg_wdata[7:0];
            if (ctrl_wr) hcnt <= 2'd0;
            else if (gen_q) begin
                hist <= {hist[15:0], tx_out.data};
                hcnt <= (hcnt == 2'd3) ? hcnt : hcnt + 2'd1;
            end
        end
    end
    sequence s_rd(logic [3:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_b1_in;
        tx_slot.valid && tx_slot.b1 && !tx_slot.e1 && ctrl[3];
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_b1val_readback: assert property (s_rd(ppu_pkg::REG_B1VAL) |=> reg_rdata[7:0] == b1v)
        else $error("signature value read back wrong");
    a_tx_follow:
        assert property (tx_slot.valid |=> tx_out.valid && tx_out.slot == $past(tx_slot.slot))
        else $error("transmit slot not passed on after one cycle");
    a_tx_quiet: assert property (!tx_slot.valid |=> !tx_out.valid)
        else $error("transmit valid without a slot");
    a_b1_insert: assert property (s_b1_in |=> tx_out.data == b1v)
        else $error("signature byte not inserted");
    a_e1_insert:
        assert property (tx_slot.valid && tx_slot.e1 && !tx_slot.b1 && ctrl[3] |=> tx_out.data == ~b1v)
        else $error("complement byte not inserted");
    a_prbs_next: assert property (gen_q && hcnt == 2'd3 |-> tx_out.data == pnx[7:0])
        else $error("generated byte does not follow the last three");
    a_irq_masked:
        assert property (reg_wr && reg_addr == ppu_pkg::REG_INTMSK && reg_wdata[3:0] == 4'h0 |=> !irq)
        else $error("interrupt high with all events masked");
endmodule : ppu_props

bind ppu_top ppu_props i_props (.clock(clock), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_in(rx_in),
    .tx_slot(tx_slot), .tx_out(tx_out), .irq(irq));

// file: tb/ppu_top_test.sv
/* Self-checking bench of the pattern unit with a far-end pattern source.
   Assumes twelve STS-1 paths and clock enable held high. */
module ppu_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clock = 1'b0;
    logic               nrst = 1'b0;
    logic [3:0]         reg_addr = 4'h0;
    logic [15:0]        reg_wdata = 16'h0000;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [15:0]        reg_rdata;
    ppu_pkg::ppu_byte_t rx_in;
    ppu_pkg::ppu_byte_t tx_out;
    ppu_pkg::ppu_byte_t tx_slot = '0;
    logic               irq;
    logic               incr = 1'b0;
    logic               inj_ld = 1'b0;
    logic [3:0]         inj_n = 4'h0;
    logic               rdc = 1'b0;
    logic               rdc_d = 1'b0;
    logic               tx_on = 1'b0;
    logic [15:0]        rv;
    logic [15:0]        eq[$];
    logic [15:0]        mq[$];
    logic [7:0]         txq[$];
    logic [22:0]        gs [12];
    logic [7:0]         bv;
    logic [3:0]         tk = 4'h0;
    logic [31:0]        r;
    logic [30:0]        nx;
    integer             seed = 32'h0132_dee3;
    int                 error_cnt = 0;
    int                 cmp_count = 0;

    ppu_top i_dut (.clock(clock), .nrst(nrst), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_in(rx_in), .tx_slot(tx_slot),
        .tx_out(tx_out), .irq(irq));
    ppu_src i_src (.clock(clock), .nrst(nrst), .incr(incr), .inj_ld(inj_ld), .inj_n(inj_n), .rx_in(rx_in));

    always #20 clock = ~clock;

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    // A checked read leaves its expectation for the read monitor.
    task automatic rd(input logic [3:0] a, input logic c, input logic [15:0] e, input logic [15:0] m);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        rdc      <= c;
        if (c) begin
            eq.push_back(e);
            mq.push_back(m);
        end
        @(posedge clock);
        reg_rd <= 1'b0;
        rdc    <= 1'b0;
        @(negedge clock);
        rv = reg_rdata;
    endtask : rd

    task automatic bwait;
        int n;
        n = 0;
        rv = 16'h8000;
        while (rv[15] && n < 64) begin
            rd(ppu_pkg::REG_IND, 1'b0, 16'h0000, 16'h0000);
            n++;
        end
        if (rv[15]) chk("busy", rv, 16'h0000);
    endtask : bwait

    task automatic ind(input logic [15:0] e);
        bwait();
        wr(ppu_pkg::REG_IND, 16'h0010);
        bwait();
        rd(ppu_pkg::REG_DATA, 1'b1, e, 16'hFFFF);
    endtask : ind

    task automatic inj(input logic [3:0] n);
        @(posedge clock);
        inj_ld <= 1'b1;
        inj_n  <= n;
        @(posedge clock);
        inj_ld <= 1'b0;
    endtask : inj

    always @(posedge clock) rdc_d <= rdc;

    always @(negedge clock) begin
        if (rdc_d) chk("reg_rdata", reg_rdata & mq.pop_front(), eq.pop_front());
        if (tx_out.valid && txq.size() > 0) chk("tx_data", {8'h00, tx_out.data}, {8'h00, txq.pop_front()});
    end

    // Random slot markers; the expected byte is noted as the slot is driven.
    always @(posedge clock) begin
        r = $random(seed);
        if (tx_on) begin
            tx_slot <= '{1'b1, tk, r[2:0] == 3'd0, r[2:0] == 3'd1, r[15:8]};
            if (r[2:0] == 3'd0) txq.push_back(bv);
            else if (r[2:0] == 3'd1) txq.push_back(~bv);
            else begin
                nx = ppu_tb_pkg::prbs8(gs[tk]);
                gs[tk] = nx[30:8];
                txq.push_back(nx[7:0]);
            end
            tk = (tk == 4'hB) ? 4'h0 : tk + 4'h1;
        end else tx_slot <= '0;
    end

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        results();
    end

    initial begin
        bv = $random(seed);
        foreach (gs[i]) gs[i] = 23'h7F_FFFF;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        wr(ppu_pkg::REG_INTMSK, 16'h000F);
        wr(ppu_pkg::REG_B1VAL, {8'h00, bv});
        wr(ppu_pkg::REG_PATH, 16'h0000);
        wr(ppu_pkg::REG_CTRL, 16'h000B);
        tx_on = 1'b1;
        rd(ppu_pkg::REG_B1VAL, 1'b1, {8'h00, bv}, 16'h00FF);
        rd(4'h9, 1'b1, 16'h0000, 16'hFFFF);
        repeat (300) @(posedge clock);
        tx_on = 1'b0;
        rd(ppu_pkg::REG_INTST, 1'b1, 16'h0001, 16'h0001);
        chk("irq", {15'h0000, irq}, 16'h0001);
        wr(ppu_pkg::REG_INTST, 16'h000F);
        repeat (3) begin
            inj(4'h1);
            repeat (40) @(posedge clock);
        end
        ind(16'h0003);
        ind(16'h0000);
        inj(4'h8);
        repeat (150) @(posedge clock);
        rd(ppu_pkg::REG_INTST, 1'b1, 16'h0006, 16'h0006);
        ind(16'h0004);
        repeat (300) @(posedge clock);
        rd(ppu_pkg::REG_INTST, 1'b1, 16'h0001, 16'h0001);
        wr(ppu_pkg::REG_INTST, 16'h000F);
        wr(ppu_pkg::REG_CTRL, 16'h001B);
        repeat (300) @(posedge clock);
        rd(ppu_pkg::REG_INTST, 1'b1, 16'h0001, 16'h0001);
        wr(ppu_pkg::REG_INTST, 16'h000F);
        incr <= 1'b1;
        wr(ppu_pkg::REG_CTRL, 16'h0007);
        repeat (300) @(posedge clock);
        rd(ppu_pkg::REG_INTST, 1'b1, 16'h0003, 16'h0003);
        wr(ppu_pkg::REG_INTMSK, 16'h0000);
        @(negedge clock);
        chk("irq", {15'h0000, irq}, 16'h0000);
        results();
    end
endmodule : ppu_top_test
